/* cpps_status_page.sv */
// Purpose: Per-port status and control register page of a two-port cable PHY
// Assumes: Port inputs are asynchronous pins and are synchronised here
// Notes: Bus reset leaves every field of this page unchanged
// Operation
// - Page 0 selected in base register 7 shows the port chosen by port select.
// - An unimplemented selected port reads all page registers as zero.
// - Pair A line state code: 11 Z, 10 zero, 01 one, 00 invalid.
// - Pair B line state uses the same coding as pair A.
// - Role bit 1 for child; disconnected, disabled or suspended ports read child.
// - Connected bit sets after 341 ms stable; hardware reset clears, bus reset keeps.
// - Connected bit means physical attachment only, not an active port.
// - Bias bit reads 1 only after 52 us continuous incoming bias.
// - Writing 1 to disable bit disables port; hardware reset clears, bus reset keeps.
// - Peer speed field: 000 S100, 001 S200, 010 S400; higher codes invalid.
// - Peer speed never reported above 010.
// - Enabled port event sets the global port-event flag and notifies the link.
// - Fault sets, port held suspended, on resume without bias or suspend with bias.
// - Writing 1 clears fault; hardware reset clears, bus reset does not.
// - Port-event flag sets on bias, connect, disable or fault change of enabled port.
// - Four-bit port select numbers from 0; hardware reset clears, bus reset keeps.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`include "cpps_regs.svh"
module cpps_status_page #(
    parameter int NUM_PORTS = 2,
    parameter int CONN_DEB_CYC = `CPPS_CONN_DEB_CYC,
    parameter int BIAS_DEB_CYC = `CPPS_BIAS_DEB_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic bus_reset,
    input wire cpps_pkg::cpps_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire cpps_pkg::cpps_port_in_t [NUM_PORTS-1:0] port_in,
    output logic [NUM_PORTS-1:0] port_disable,
    output logic [NUM_PORTS-1:0] port_hold_suspend,
    output logic link_notify,
    output logic irq
);
    localparam int CW = $clog2(CONN_DEB_CYC + 1);
    localparam int BW = $clog2(BIAS_DEB_CYC + 1);

    cpps_pkg::cpps_port_in_t [NUM_PORTS-1:0] sync1_reg;
    cpps_pkg::cpps_port_in_t [NUM_PORTS-1:0] sync2_reg;
    logic [2:0] page_reg;
    logic [3:0] port_sel_reg;
    logic [NUM_PORTS-1:0] dis_reg;
    logic [NUM_PORTS-1:0] inten_reg;
    logic [NUM_PORTS-1:0] fault_reg;
    logic [NUM_PORTS-1:0] conn_reg;
    logic [NUM_PORTS-1:0] bias_reg;
    logic [CW-1:0] conn_cnt_reg [NUM_PORTS];
    logic [BW-1:0] bias_cnt_reg [NUM_PORTS];
    logic [NUM_PORTS-1:0] conn_d_reg;
    logic [NUM_PORTS-1:0] bias_d_reg;
    logic [NUM_PORTS-1:0] dis_d_reg;
    logic [NUM_PORTS-1:0] fault_d_reg;
    logic evt_flag_reg;
    logic evt_mask_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic page_hit;
    logic port_ok;
    logic [NUM_PORTS-1:0] sel_wr;
    logic [NUM_PORTS-1:0] port_evt;
    logic evt_any;
    logic evt_clr;
    logic wr_base7;
    logic wr_line;
    logic wr_speed;
    logic wr_int_status;
    logic wr_int_mask;
    logic [NUM_PORTS-1:0] status_chg;
    logic [NUM_PORTS-1:0] fault_cond;
    logic [NUM_PORTS-1:0] role_child;

    // Returns the value of one bit field of the write data
    function automatic logic wbit(input logic [7:0] d, input int pos);
        return d[pos];
    endfunction

    // Clamp speed codes to the detectable range
    function automatic logic [2:0] clamp_speed(input logic [2:0] s);
        return (s > `CPPS_SPEED_MAX) ? `CPPS_SPEED_MAX : s;
    endfunction

    // True once a debounce counter has covered its full interval
    function automatic logic deb_done(input int cnt, input int limit);
        return cnt >= limit - 1;
    endfunction

    // One-cycle change of a level against its delayed copy
    function automatic logic changed(input logic now_v, input logic prev_v);
        return now_v ^ prev_v;
    endfunction

    // True when the port select names port number idx
    function automatic logic port_hit(input logic [3:0] sel, input int idx);
        return 32'(sel) == idx;
    endfunction

    // Assembles the base register 7 byte
    function automatic logic [7:0] base7_word(input logic [2:0] page, input logic [3:0] port);
        logic [7:0] w;
        w = 8'h00;
        w[`CPPS_PAGE_LSB +: 3] = page;
        w[`CPPS_PORT_LSB +: 4] = port;
        return w;
    endfunction

    // Assembles the line and link state byte of one port
    function automatic logic [7:0] line_word(
        input cpps_pkg::cpps_port_in_t s,
        input logic child,
        input logic conn,
        input logic bias,
        input logic dis
    );
        logic [7:0] w;
        w = 8'h00;
        w[`CPPS_ASTATE_LSB +: 2] = s.pair_a;
        w[`CPPS_BSTATE_LSB +: 2] = s.pair_b;
        w[`CPPS_CHILD_BIT] = child;
        w[`CPPS_CONN_BIT] = conn;
        w[`CPPS_BIAS_BIT] = bias;
        w[`CPPS_DIS_BIT] = dis;
        return w;
    endfunction

    // Assembles the peer speed and event control byte of one port
    function automatic logic [7:0] speed_word(
        input logic [2:0] speed,
        input logic inten,
        input logic fault
    );
        logic [7:0] w;
        w = 8'h00;
        w[`CPPS_SPEED_LSB +: 3] = clamp_speed(speed);
        w[`CPPS_INTEN_BIT] = inten;
        w[`CPPS_FAULT_BIT] = fault;
        return w;
    endfunction

    // Two-flop synchroniser for all raw port inputs
    // Multi-bit codes may show one mixed sample while the pins change
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= port_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign page_hit = (page_reg == `CPPS_STATUS_PAGE);
    assign port_ok = (32'(port_sel_reg) < NUM_PORTS);

    // Register write decodes
    assign wr_base7 = bus_req.wr && (bus_req.addr == `CPPS_BASE7_ADDR);
    assign wr_line = bus_req.wr && (bus_req.addr == `CPPS_LINE_STATE_ADDR);
    assign wr_speed = bus_req.wr && (bus_req.addr == `CPPS_SPEED_EVT_ADDR);
    assign wr_int_status = bus_req.wr && (bus_req.addr == `CPPS_INT_STATUS_ADDR);
    assign wr_int_mask = bus_req.wr && (bus_req.addr == `CPPS_INT_MASK_ADDR);

    // Base register 7 page and port select; bus reset does not touch them
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            page_reg <= `CPPS_PAGE_RST;
            port_sel_reg <= `CPPS_PORT_RST;
        end else if (wr_base7) begin
            page_reg <= bus_req.wdata[`CPPS_PAGE_LSB +: 3];
            port_sel_reg <= bus_req.wdata[`CPPS_PORT_LSB +: 4];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : gen_port
            assign sel_wr[g] = page_hit && port_ok && port_hit(port_sel_reg, g);

            // Connection debounce: set only after a full stable interval
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    conn_cnt_reg[g] <= '0;
                    conn_reg[g] <= 1'b0;
                end else if (!sync2_reg[g].connected_raw) begin
                    conn_cnt_reg[g] <= '0;
                    conn_reg[g] <= 1'b0;
                end else if (deb_done(32'(conn_cnt_reg[g]), CONN_DEB_CYC)) begin
                    conn_reg[g] <= 1'b1;
                end else begin
                    conn_cnt_reg[g] <= conn_cnt_reg[g] + 1'b1;
                end
            end

            // Bias debounce
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    bias_cnt_reg[g] <= '0;
                    bias_reg[g] <= 1'b0;
                end else if (!sync2_reg[g].bias_raw) begin
                    bias_cnt_reg[g] <= '0;
                    bias_reg[g] <= 1'b0;
                end else if (deb_done(32'(bias_cnt_reg[g]), BIAS_DEB_CYC)) begin
                    bias_reg[g] <= 1'b1;
                end else begin
                    bias_cnt_reg[g] <= bias_cnt_reg[g] + 1'b1;
                end
            end

            // Disable and interrupt enable controls; bus reset leaves them alone
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    dis_reg[g] <= 1'b0;
                    inten_reg[g] <= 1'b0;
                end else if (bus_req.wr && sel_wr[g]) begin
                    if (wr_line) begin
                        dis_reg[g] <= wbit(bus_req.wdata, `CPPS_DIS_BIT);
                    end
                    if (wr_speed) begin
                        inten_reg[g] <= wbit(bus_req.wdata, `CPPS_INTEN_BIT);
                    end
                end
            end

            // Resume without bias or suspend with bias is a fault
            assign fault_cond[g] = (sync2_reg[g].resuming && !bias_reg[g])
                || (sync2_reg[g].suspending && bias_reg[g]);

            // Fault: hardware set wins over a write-one clear
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    fault_reg[g] <= 1'b0;
                end else if (fault_cond[g]) begin
                    fault_reg[g] <= 1'b1;
                end else if (wr_speed && sel_wr[g] && wbit(bus_req.wdata, `CPPS_FAULT_BIT)) begin
                    fault_reg[g] <= 1'b0;
                end
            end

            // Previous values for change detection
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    conn_d_reg[g] <= 1'b0;
                    bias_d_reg[g] <= 1'b0;
                    dis_d_reg[g] <= 1'b0;
                    fault_d_reg[g] <= 1'b0;
                end else begin
                    conn_d_reg[g] <= conn_reg[g];
                    bias_d_reg[g] <= bias_reg[g];
                    dis_d_reg[g] <= dis_reg[g];
                    fault_d_reg[g] <= fault_reg[g];
                end
            end

            assign status_chg[g] = changed(conn_reg[g], conn_d_reg[g]) || changed(bias_reg[g], bias_d_reg[g])
                || changed(dis_reg[g], dis_d_reg[g]) || changed(fault_reg[g], fault_d_reg[g]);
            assign port_evt[g] = inten_reg[g] && status_chg[g];

            // Disconnected, disabled, suspended or faulted ports report as child
            assign role_child[g] = !sync2_reg[g].is_parent || !conn_reg[g] || dis_reg[g]
                || sync2_reg[g].suspended || fault_reg[g];
        end
    endgenerate

    assign port_disable = dis_reg;
    assign port_hold_suspend = fault_reg;
    assign evt_any = |port_evt;
    assign evt_clr = wr_int_status && bus_req.wdata[`CPPS_EVT_BIT];

    // Global port-event flag: set beats write-one clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_flag_reg <= 1'b0;
        end else if (evt_any) begin
            evt_flag_reg <= 1'b1;
        end else if (evt_clr) begin
            evt_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_mask_reg <= 1'b0;
        end else if (wr_int_mask) begin
            evt_mask_reg <= bus_req.wdata[`CPPS_EVT_BIT];
        end
    end

    // Level interrupt follows the flag only while it is unmasked
    assign irq = evt_flag_reg && evt_mask_reg;
    assign link_notify = evt_flag_reg;

    // Read mux for the selected port
    always_comb begin
        int p;
        cpps_pkg::cpps_port_in_t s;
        p = 32'(port_sel_reg);
        s = '0;
        rdata_next = 8'h00;
        // Out-of-range ports keep an all-zero sample
        if (port_ok) begin
            s = sync2_reg[p[$clog2(NUM_PORTS > 1 ? NUM_PORTS : 2)-1:0]];
        end
        unique case (bus_req.addr)
            `CPPS_BASE7_ADDR: begin
                rdata_next = base7_word(page_reg, port_sel_reg);
            end
            `CPPS_LINE_STATE_ADDR: begin
                if (page_hit && port_ok) begin
                    rdata_next = line_word(s, role_child[p], conn_reg[p], bias_reg[p], dis_reg[p]);
                end
            end
            `CPPS_SPEED_EVT_ADDR: begin
                if (page_hit && port_ok) begin
                    rdata_next = speed_word(s.peer_speed, inten_reg[p], fault_reg[p]);
                end
            end
            `CPPS_INT_STATUS_ADDR: begin
                rdata_next[`CPPS_EVT_BIT] = evt_flag_reg;
            end
            `CPPS_INT_MASK_ADDR: begin
                rdata_next[`CPPS_EVT_BIT] = evt_mask_reg;
            end
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= bus_req.rd ? rdata_next : 8'h00;
        end
    end

    assign rdata = rdata_reg;
endmodule // cpps_status_page

/* cpps_regs.svh */
// Purpose: Constants for the per-port status page (offsets, field positions, resets, timing)
// Assumes: Register addresses are 4-bit PHY register numbers
// Notes: Included by the page module; the package does not include it
`ifndef CPPS_REGS_SVH
`define CPPS_REGS_SVH
`define CPPS_ADDR_W 4
`define CPPS_BASE7_ADDR 4'h7
`define CPPS_LINE_STATE_ADDR 4'h8
`define CPPS_SPEED_EVT_ADDR 4'h9
`define CPPS_INT_STATUS_ADDR 4'hA
`define CPPS_INT_MASK_ADDR 4'hB
// Base register 7 layout: page select [7:5], port select [3:0]
`define CPPS_PAGE_LSB 5
`define CPPS_PORT_LSB 0
`define CPPS_STATUS_PAGE 3'h0
`define CPPS_PAGE_RST 3'h0
`define CPPS_PORT_RST 4'h0
// Line/link register: A state [7:6], B state [5:4], child 3, conn 2, bias 1, dis 0
`define CPPS_ASTATE_LSB 6
`define CPPS_BSTATE_LSB 4
`define CPPS_CHILD_BIT 3
`define CPPS_CONN_BIT 2
`define CPPS_BIAS_BIT 1
`define CPPS_DIS_BIT 0
// Speed/event register: speed [7:5], int enable 4, fault 3
`define CPPS_SPEED_LSB 5
`define CPPS_INTEN_BIT 4
`define CPPS_FAULT_BIT 3
`define CPPS_SPEED_MAX 3'h2
// Interrupt status bit 0 is the port-event flag
`define CPPS_EVT_BIT 0
// Debounce times and their cycle counts at 50 MHz
`define CPPS_CLK_HZ 50000000
`define CPPS_CONN_DEB_MS 341
`define CPPS_BIAS_DEB_US 52
`define CPPS_CONN_DEB_CYC ((`CPPS_CLK_HZ / 1000) * `CPPS_CONN_DEB_MS)
`define CPPS_BIAS_DEB_CYC (((`CPPS_CLK_HZ / 1000000) * `CPPS_BIAS_DEB_US))
`endif

/* cpps_pkg.sv */
// Purpose: Types for the per-port status page
// Assumes: Constants live in cpps_regs.svh
// Notes: Line-state and speed codes kept as types
package cpps_pkg;
    typedef enum logic [1:0] {
        CPPS_LS_INVALID = 2'h0,
        CPPS_LS_ONE = 2'h1,
        CPPS_LS_ZERO = 2'h2,
        CPPS_LS_Z = 2'h3
    } cpps_line_state_t;

    typedef enum logic [2:0] {
        CPPS_S100 = 3'h0,
        CPPS_S200 = 3'h1,
        CPPS_S400 = 3'h2
    } cpps_speed_t;

    // Raw state of one port from the analog front end and port state logic
    typedef struct packed {
        logic [1:0] pair_a;
        logic [1:0] pair_b;
        logic is_parent;
        logic connected_raw;
        logic bias_raw;
        logic suspended;
        logic resuming;
        logic suspending;
        logic [2:0] peer_speed;
    } cpps_port_in_t;

    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cpps_bus_req_t;
endpackage

/* cpps_status_page_chk.sv */
// Purpose: Port-level assertions for the per-port status page
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every page instance
`timescale 1ns/1ns
module cpps_status_page_chk #(
    parameter int NUM_PORTS = 2
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic bus_reset,
    input wire cpps_pkg::cpps_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire cpps_pkg::cpps_port_in_t [NUM_PORTS-1:0] port_in,
    input wire logic [NUM_PORTS-1:0] port_disable,
    input wire logic [NUM_PORTS-1:0] port_hold_suspend,
    input wire logic link_notify,
    input wire logic irq
);
    default clocking c_clk @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_rd(a);
        bus_req.rd && bus_req.addr == a;
    endsequence
    property p_rd_slot;
        !bus_req.rd |=> rdata == 8'h00;
    endproperty
    a_rd_slot: assert property (p_rd_slot) else $error("read data outside read slot");
    property p_unmapped;
        bus_req.rd && bus_req.addr >= 4'hC |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address not zero");
    property p_reserved;
        s_rd(4'h9) |=> rdata[2:0] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
    property p_clamp;
        s_rd(4'h9) |=> rdata[7:5] <= 3'h2;
    endproperty
    a_clamp: assert property (p_clamp) else $error("speed code above limit");
    property p_child;
        s_rd(4'h8) |=> rdata == 8'h00 || rdata[3] || (rdata[2] && !rdata[0]);
    endproperty
    a_child: assert property (p_child) else $error("idle port not child");
    property p_irq;
        irq |-> link_notify;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without event flag");
    property p_dis_write;
        !$stable(port_disable) |-> $past(bus_req.wr) && $past(bus_req.addr) == 4'h8;
    endproperty
    a_dis_write: assert property (p_dis_write) else $error("disable changed without write");
    property p_fault_w1c;
        $fell(port_hold_suspend[0]) |-> $past(bus_req.wr) && $past(bus_req.addr) == 4'h9 && $past(bus_req.wdata[3]);
    endproperty
    a_fault_w1c: assert property (p_fault_w1c) else $error("fault cleared without write");
    property p_flag_sticky;
        link_notify && !(bus_req.wr && bus_req.addr == 4'hA && bus_req.wdata[0]) |=> link_notify;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("event flag lost");
endmodule // cpps_status_page_chk
bind cpps_status_page cpps_status_page_chk #(.NUM_PORTS(NUM_PORTS)) i_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .bus_reset(bus_reset), .bus_req(bus_req), .rdata(rdata),
    .port_in(port_in), .port_disable(port_disable), .port_hold_suspend(port_hold_suspend),
    .link_notify(link_notify), .irq(irq)
);

/* cpps_peer_model.sv */
// Purpose: Peer cable device seen at one port
// Assumes: Commands from the bench are already legal
// Notes: A detached peer gives no bias, no role and a zero speed
`timescale 1ns/1ns
module cpps_peer_model (
    input wire logic ref_clk,
    input wire logic attach,
    input wire logic bias_on,
    input wire cpps_pkg::cpps_port_in_t cmd,
    output cpps_pkg::cpps_port_in_t port_in
);
    cpps_pkg::cpps_port_in_t nxt;
    always_comb begin
        nxt = cmd;
        nxt.connected_raw = attach;
        nxt.bias_raw = attach && bias_on;
        nxt.is_parent = attach && cmd.is_parent;
        nxt.peer_speed = attach ? cmd.peer_speed : 3'h0;
    end
    initial port_in = '0;
    always @(posedge ref_clk) begin
        port_in <= nxt;
    end
endmodule // cpps_peer_model

/* cable_phy_port_status_page_test.sv */
// Purpose: Self-checking bench for the per-port status page
// Assumes: Short debounce counts of 20 and 10 cycles
// Notes: Random line states and speeds beside corner cases
`timescale 1ns/1ns
module cable_phy_port_status_page_test;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic bus_reset = 1'b0;
    cpps_pkg::cpps_bus_req_t req = '0;
    cpps_pkg::cpps_port_in_t cmd [2];
    logic [1:0] attach = 2'h0;
    logic [1:0] bias_on = 2'h0;
    wire cpps_pkg::cpps_port_in_t [1:0] pin;
    logic [7:0] rdata;
    logic [1:0] dis;
    logic [1:0] hold;
    logic notify;
    logic irq;
    logic [1:0] a;
    logic [2:0] s;
    int n_mismatch = 0;
    int checks = 0;
    always #10 ref_clk = ~ref_clk;
    cpps_status_page #(.NUM_PORTS(2), .CONN_DEB_CYC(20), .BIAS_DEB_CYC(10)) i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .bus_reset(bus_reset), .bus_req(req), .rdata(rdata),
        .port_in(pin), .port_disable(dis), .port_hold_suspend(hold), .link_notify(notify), .irq(irq)
    );
    for (genvar i = 0; i < 2; i++) begin : g_peer
        cpps_peer_model i_peer (
            .ref_clk(ref_clk), .attach(attach[i]), .bias_on(bias_on[i]), .cmd(cmd[i]), .port_in(pin[i])
        );
    end
    task automatic go(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, input logic [7:0] e);
        @(posedge ref_clk);
        req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        @(negedge ref_clk);
        check(rdata, e);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        final_report;
    end
    initial begin
        cmd[0] = '0;
        cmd[1] = '0;
        cmd[0].is_parent = 1'b1;
        void'($urandom(32'h6DFAFFF4));
        go(16);
        arst_n <= 1'b1;
        rd(4'h7, 8'h00);
        rd(4'h8, 8'h08);
        rd(4'h9, 8'h00);
        for (int i = 0; i < 8; i++) begin
            a = (i < 4) ? i[1:0] : 2'($urandom);
            go(1);
            cmd[0].pair_a <= a;
            cmd[0].pair_b <= ~a;
            go(5);
            rd(4'h8, {a, ~a, 4'h8});
        end
        go(1);
        cmd[0].pair_a <= 2'h3;
        cmd[0].pair_b <= 2'h3;
        attach[0] <= 1'b1;
        go(10);
        rd(4'h8, 8'hF8);
        go(30);
        rd(4'h8, 8'hF4);
        go(1);
        bias_on[0] <= 1'b1;
        go(6);
        rd(4'h8, 8'hF4);
        go(20);
        rd(4'h8, 8'hF6);
        for (int i = 0; i < 10; i++) begin
            s = (i < 2) ? 3'($urandom) : 3'(i - 2);
            go(1);
            cmd[0].peer_speed <= s;
            go(5);
            rd(4'h9, {(s > 3'h2) ? 3'h2 : s, 5'h00});
        end
        rd(4'hA, 8'h00);
        wr(4'h9, 8'h10);
        wr(4'hB, 8'h01);
        bias_on[0] <= 1'b0;
        go(8);
        rd(4'hA, 8'h01);
        check({7'h00, notify}, 8'h01);
        check({7'h00, irq}, 8'h01);
        wr(4'hB, 8'h00);
        @(negedge ref_clk);
        check({7'h00, irq}, 8'h00);
        wr(4'hB, 8'h01);
        wr(4'hA, 8'h01);
        rd(4'hA, 8'h00);
        check({7'h00, notify}, 8'h00);
        wr(4'h8, 8'h01);
        @(negedge ref_clk);
        check({6'h00, dis}, 8'h01);
        rd(4'h8, 8'hFD);
        go(1);
        bus_reset <= 1'b1;
        go(3);
        bus_reset <= 1'b0;
        rd(4'h8, 8'hFD);
        rd(4'h9, 8'h50);
        wr(4'h8, 8'h00);
        for (int k = 0; k < 2; k++) begin
            go(1);
            bias_on[0] <= k[0];
            go(20);
            cmd[0].resuming <= !k[0];
            cmd[0].suspending <= k[0];
            go(8);
            cmd[0].resuming <= 1'b0;
            cmd[0].suspending <= 1'b0;
            @(negedge ref_clk);
            check({6'h00, hold}, 8'h01);
            rd(4'h9, 8'h58);
            wr(4'h9, 8'h18);
            rd(4'h9, 8'h50);
        end
        wr(4'h7, 8'h01);
        rd(4'h8, 8'h08);
        wr(4'h7, 8'h02);
        rd(4'h8, 8'h00);
        rd(4'h9, 8'h00);
        wr(4'h7, 8'h20);
        rd(4'h8, 8'h00);
        wr(4'h7, 8'h00);
        wr(4'hC, 8'hFF);
        rd(4'hC, 8'h00);
        wr(4'h9, 8'h17);
        rd(4'h9, 8'h50);
        final_report;
    end
endmodule // cable_phy_port_status_page_test
